// file: rtl/rmrc_receive_control.sv
// Notes on behaviour
// - Clearing receive enable aborts and drops frame
// - Entering rx-streaming sets receive enable, entering tx-streaming clears it
// - Radio listens for assessment and acks anyway
// - Parse disable skips parsing, checks CRC only
// - Security start runs, self-clears, raises pass/fail
// - Append link quality and signal strength bytes
// - Append channel, format, rate byte MSB first
// - Append frequency offset byte when enabled
// - Full buffer on valid frame gives overflow
// - Streaming full bit shows current buffer valid
// - Duplicate reject drops matching frame, flags it
// - Without reject duplicates are processed normally
// - Status bit mirrors last standard ack pending
// - Sent ack carries host ack-pending bit
// - Auto repeat retransmits frames with Repeat set
// - Auto acknowledge answers frames requesting ack
// - Adaptive channel takes ack channel from frame
// - Adaptive rate takes ack rate from frame
// - Receive done once per accepted frame
// - Filtered flag on frame rejected by filters
// - Interrupt flags clear when their register read
// - No free buffer drops frame with overflow
// - Mode codes select packet, rx-streaming and tx-streaming

module rmrc_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready,
  // Level
  output logic                  empty
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial begin
    if (DEPTH < 2 || WIDTH < 1) begin
      $error("rmrc_fifo: unsupported size");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign empty     = (count == '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr      <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule // rmrc_fifo

module rmrc_receive_control #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Serial register port
  input  wire logic        spi_sck,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // Mode and transmit configuration
  input  wire logic [1:0]  transceiver_mode,
  input  wire logic [3:0]  channel_number,
  input  wire logic [2:0]  data_rate_code,
  input  wire logic        crc_check_enable,
  // Radio listen requests
  input  wire logic        cca_request,
  input  wire logic        ack_wait,
  output logic             radio_rx_on,
  // Demodulated frame
  input  wire logic        rx_frame_start,
  input  wire logic        rx_byte_valid,
  input  wire logic [7:0]  rx_byte,
  output logic             rx_byte_ready,
  input  wire logic        rx_frame_end,
  input  wire logic        rx_crc_ok,
  input  wire logic        rx_filter_pass,
  input  wire logic        rx_is_ack,
  input  wire logic        rx_std_format,
  input  wire logic        rx_frame_pending,
  input  wire logic        rx_repeat,
  input  wire logic        rx_ack_request,
  input  wire logic [15:0] rx_src_addr,
  input  wire logic [7:0]  rx_seq_num,
  input  wire logic [3:0]  ack_info_channel,
  input  wire logic [2:0]  ack_info_rate,
  // Receive status vector
  input  wire logic [7:0]  rx_link_quality,
  input  wire logic [7:0]  rx_signal_strength,
  input  wire logic [3:0]  rx_channel,
  input  wire logic        frame_format_type,
  input  wire logic [2:0]  rx_data_rate,
  input  wire logic [7:0]  freq_offset_measurement,
  // Packet buffer write
  output logic             buf_wr_valid,
  output logic [7:0]       buf_wr_data,
  input  wire logic        buf_wr_ready,
  output logic             buf_commit,
  output logic             buf_discard,
  // Security engine
  output logic             sec_start,
  input  wire logic        sec_done,
  input  wire logic        sec_pass,
  // Transmit requests
  output logic             ack_tx_req,
  output logic [3:0]       ack_channel,
  output logic [2:0]       ack_rate,
  output logic             ack_frame_pending,
  output logic             repeat_tx_req,
  // Stream time-out event
  input  wire logic        stream_timeout
);
  initial begin
    if (FIFO_DEPTH < 2) begin
      $error("rmrc_receive_control: FIFO_DEPTH too small");
    end
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {RMRC_IDLE, RMRC_RECV, RMRC_APPEND, RMRC_FINISH} rmrc_fsm_t;

  typedef struct packed {
    logic        sck_s1, sck_s2, sck_d, cs_s1, cs_s2, mosi_s1, mosi_s2;
    logic [2:0]  bit_cnt;
    logic [7:0]  rx_sh;
    logic [7:0]  tx_sh;
    logic        cmd_done;
    logic        wr_cmd;
    logic [6:0]  addr;
    logic        miso, miso_oe;
    logic [7:0]  ctrl_one;
    logic [7:0]  ctrl_two;
    logic [1:0]  full_cnt;
    logic [7:0]  flags;
    logic [1:0]  prev_mode;
    rmrc_fsm_t   fsm;
    logic        keep, aborted, good;
    logic [1:0]  app_idx;
    logic [31:0] status_vec;
    logic [15:0] last_src;
    logic [7:0]  last_seq;
    logic        last_valid;
    logic        commit, discard, sec_go, ack_req, rpt_req;
    logic [3:0]  ack_ch;
    logic [2:0]  ack_dr;
    logic        ack_fp, rx_on;
  } rmrc_state_t;

  rmrc_state_t st;
  rmrc_state_t next_st;

  logic       fifo_in_valid;
  logic [7:0] fifo_in_data;
  logic       fifo_in_ready;
  logic       fifo_empty;
  logic       fifo_out_valid;
  logic [7:0] fifo_out_data;

  function automatic logic [7:0] reg_read(input rmrc_state_t s);
    logic [7:0] v;
    v = 8'h00;
    case (s.addr)
      rmrc_pkg::ADDR_RX_CTRL_ONE: begin
        v = s.ctrl_one & 8'hFE;
      end
      rmrc_pkg::ADDR_RX_CTRL_TWO: begin
        v = s.ctrl_two;
        v[rmrc_pkg::C2_BUFFER_FULL] = (s.full_cnt != 2'h0);
      end
      rmrc_pkg::ADDR_RX_INT_FLAGS: begin
        v = s.flags & rmrc_pkg::IF_IMPL_MASK;
      end
      default: begin
        v = 8'h00;
      end
    endcase
    return v;
  endfunction

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    logic       sck_rise;
    logic       sck_fall;
    logic [7:0] byte_in;
    logic [7:0] set_mask;
    logic [7:0] clr_mask;
    logic [1:0] buf_limit;
    logic       dup_hit;
    logic       take;
    sck_rise      = 1'b0;
    sck_fall      = 1'b0;
    byte_in       = 8'h00;
    set_mask      = 8'h00;
    clr_mask      = 8'h00;
    buf_limit     = rmrc_pkg::BUFS_PACKET;
    dup_hit       = 1'b0;
    take          = 1'b0;
    fifo_in_valid = 1'b0;
    fifo_in_data  = rx_byte;
    next_st       = st;
    next_st.commit  = 1'b0;
    next_st.discard = 1'b0;
    next_st.sec_go  = 1'b0;
    next_st.ack_req = 1'b0;
    next_st.rpt_req = 1'b0;

    // Pin synchronisers; first stages feed only second stages
    next_st.sck_s1  = spi_sck;
    next_st.sck_s2  = st.sck_s1;
    next_st.sck_d   = st.sck_s2;
    next_st.cs_s1   = spi_cs_n;
    next_st.cs_s2   = st.cs_s1;
    next_st.mosi_s1 = spi_mosi;
    next_st.mosi_s2 = st.mosi_s1;
    sck_rise = st.sck_s2 && !st.sck_d;
    sck_fall = !st.sck_s2 && st.sck_d;

    // Serial slave: command byte then one data byte, mode 0
    if (st.cs_s2) begin
      next_st.bit_cnt  = 3'h0;
      next_st.cmd_done = 1'b0;
      next_st.miso_oe  = 1'b0;
    end else begin
      next_st.miso_oe = 1'b1;
      if (sck_fall) begin
        next_st.miso  = st.tx_sh[7];
        next_st.tx_sh = {st.tx_sh[6:0], 1'b0};
      end
      if (sck_rise) begin
        byte_in         = {st.rx_sh[6:0], st.mosi_s2};
        next_st.rx_sh   = byte_in;
        next_st.bit_cnt = st.bit_cnt + 3'h1;
        if (st.bit_cnt == 3'h7) begin
          if (!st.cmd_done) begin
            next_st.cmd_done = 1'b1;
            next_st.wr_cmd   = byte_in[7];
            next_st.addr     = byte_in[6:0];
            next_st.tx_sh    = reg_read(next_st);
            if (!byte_in[7] && (byte_in[6:0] == rmrc_pkg::ADDR_RX_INT_FLAGS)) begin
              clr_mask = rmrc_pkg::IF_IMPL_MASK;
            end
          end else if (st.wr_cmd) begin
            case (st.addr)
              rmrc_pkg::ADDR_RX_CTRL_ONE: begin
                next_st.ctrl_one[7:6] = byte_in[7:6];
                next_st.ctrl_one[4:1] = byte_in[4:1];
                next_st.ctrl_one[0]   = 1'b0;
                if (byte_in[rmrc_pkg::C1_SECURITY_START] && !st.ctrl_one[rmrc_pkg::C1_SECURITY_START]) begin
                  next_st.ctrl_one[rmrc_pkg::C1_SECURITY_START] = 1'b1;
                  next_st.sec_go = 1'b1;
                end
              end
              rmrc_pkg::ADDR_RX_CTRL_TWO: begin
                next_st.ctrl_two[6]   = byte_in[6];
                next_st.ctrl_two[4:0] = byte_in[4:0];
                if (!byte_in[rmrc_pkg::C2_BUFFER_FULL] && (st.full_cnt != 2'h0)) begin
                  next_st.full_cnt = st.full_cnt - 2'h1;
                end
              end
              rmrc_pkg::ADDR_RX_INT_FLAGS: begin
                clr_mask = ~byte_in & rmrc_pkg::IF_IMPL_MASK;
              end
              default: begin
              end
            endcase
          end
        end
      end
    end

    // Hardware control of receive enable on mode changes
    if (transceiver_mode != st.prev_mode) begin
      if (transceiver_mode == rmrc_pkg::MODE_TX_STREAM) begin
        next_st.ctrl_one[rmrc_pkg::C1_RECEIVE_ENABLE] = 1'b0;
      end else if (transceiver_mode == rmrc_pkg::MODE_RX_STREAM) begin
        next_st.ctrl_one[rmrc_pkg::C1_RECEIVE_ENABLE] = 1'b1;
      end
    end
    next_st.prev_mode = transceiver_mode;
    if (transceiver_mode == rmrc_pkg::MODE_RX_STREAM) begin
      buf_limit = rmrc_pkg::BUFS_STREAM;
    end

    // Security completion
    if (st.ctrl_one[rmrc_pkg::C1_SECURITY_START] && sec_done) begin
      next_st.ctrl_one[rmrc_pkg::C1_SECURITY_START] = 1'b0;
      set_mask[rmrc_pkg::IF_SEC_PASS] = sec_pass;
      set_mask[rmrc_pkg::IF_SEC_FAIL] = !sec_pass;
    end
    set_mask[rmrc_pkg::IF_STREAM_TIMEOUT] = stream_timeout;

    // Frame handling
    case (st.fsm)
      RMRC_IDLE: begin
        if (rx_frame_start && st.ctrl_one[rmrc_pkg::C1_RECEIVE_ENABLE]) begin
          next_st.fsm     = RMRC_RECV;
          next_st.keep    = (st.full_cnt < buf_limit);
          next_st.aborted = 1'b0;
          next_st.good    = 1'b0;
        end
      end
      RMRC_RECV: begin
        fifo_in_valid = rx_byte_valid && st.keep && !st.aborted;
        if (!st.ctrl_one[rmrc_pkg::C1_RECEIVE_ENABLE]) begin
          next_st.aborted = 1'b1;
        end
        if (rx_frame_end) begin
          next_st.fsm        = RMRC_FINISH;
          next_st.app_idx    = 2'h0;
          next_st.status_vec = {rx_link_quality, rx_signal_strength,
                                rx_channel, frame_format_type, rx_data_rate,
                                freq_offset_measurement};
          dup_hit = st.last_valid && (rx_src_addr == st.last_src) && (rx_seq_num == st.last_seq);
          if (next_st.aborted) begin
            take = 1'b0;
          end else if (rx_is_ack) begin
            if (rx_std_format) begin
              next_st.ctrl_two[rmrc_pkg::C2_RX_ACK_PENDING] = rx_frame_pending;
            end
          end else if (st.ctrl_one[rmrc_pkg::C1_PARSE_DISABLE]) begin
            take = !crc_check_enable || rx_crc_ok;
          end else if (crc_check_enable && !rx_crc_ok) begin
            take = 1'b0;
          end else if (!rx_filter_pass) begin
            set_mask[rmrc_pkg::IF_FILTERED] = 1'b1;
          end else if (st.ctrl_two[rmrc_pkg::C2_DUP_REJECT] && dup_hit) begin
            set_mask[rmrc_pkg::IF_DUPLICATE] = 1'b1;
          end else begin
            take = 1'b1;
          end
          if (take && !st.keep) begin
            set_mask[rmrc_pkg::IF_OVERFLOW] = 1'b1;
          end else if (take) begin
            next_st.good = 1'b1;
            next_st.fsm  = RMRC_APPEND;
            set_mask[rmrc_pkg::IF_RECEIVE_DONE] = 1'b1;
            if (!st.ctrl_one[rmrc_pkg::C1_PARSE_DISABLE]) begin
              next_st.last_src   = rx_src_addr;
              next_st.last_seq   = rx_seq_num;
              next_st.last_valid = 1'b1;
              next_st.ack_req = st.ctrl_two[rmrc_pkg::C2_AUTO_ACK] && rx_ack_request;
              next_st.rpt_req = st.ctrl_two[rmrc_pkg::C2_AUTO_REPEAT] && rx_repeat;
              next_st.ack_fp  = st.ctrl_two[rmrc_pkg::C2_TX_ACK_PENDING];
              next_st.ack_ch  = (st.ctrl_two[rmrc_pkg::C2_ADAPT_CHANNEL] && !rx_std_format) ?
                                ack_info_channel : channel_number;
              next_st.ack_dr  = (st.ctrl_two[rmrc_pkg::C2_ADAPT_RATE] && !rx_std_format) ?
                                ack_info_rate : data_rate_code;
            end
          end
        end
      end
      RMRC_APPEND: begin
        // Order: link quality, signal strength, channel/format/rate, offset
        fifo_in_data = st.status_vec[8*(3-st.app_idx) +: 8];
        take = st.ctrl_one[rmrc_pkg::C1_APPEND_LQI - 32'(st.app_idx)];
        fifo_in_valid = take;
        if (!take || fifo_in_ready) begin
          next_st.app_idx = st.app_idx + 2'h1;
          if (st.app_idx == rmrc_pkg::STATUS_FIELDS) begin
            next_st.fsm = RMRC_FINISH;
          end
        end
      end
      RMRC_FINISH: begin
        // Commit only once every byte has left, so the marker follows the data
        if (fifo_empty) begin
          next_st.commit  = st.good;
          next_st.discard = !st.good;
          if (st.good) begin
            next_st.full_cnt = st.full_cnt + 2'h1;
          end
          next_st.fsm = RMRC_IDLE;
        end
      end
      default: begin
        next_st.fsm = RMRC_IDLE;
      end
    endcase

    // Hardware set wins over host clear
    next_st.flags = ((st.flags & ~clr_mask) | set_mask) & rmrc_pkg::IF_IMPL_MASK;
    next_st.ctrl_two[rmrc_pkg::C2_BUFFER_FULL] = (next_st.full_cnt != 2'h0);
    next_st.rx_on = next_st.ctrl_one[rmrc_pkg::C1_RECEIVE_ENABLE] || cca_request || ack_wait;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      st          <= '0;
      st.ctrl_one <= rmrc_pkg::C1_RESET;
      st.ctrl_two <= rmrc_pkg::C2_RESET;
      st.flags    <= rmrc_pkg::IF_RESET;
      st.sck_s1   <= 1'b0;
      st.cs_s1    <= 1'b1;
      st.cs_s2    <= 1'b1;
      st.fsm      <= RMRC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // Byte buffer toward the packet memory
  // ---------------------------------------------------------------
  rmrc_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (fifo_in_valid),
    .in_data   (fifo_in_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out_data),
    .out_ready (buf_wr_ready),
    .empty     (fifo_empty)
  );

  assign buf_wr_valid      = fifo_out_valid;
  assign buf_wr_data       = fifo_out_data;
  assign rx_byte_ready     = fifo_in_ready && (st.fsm == RMRC_RECV);
  assign spi_miso          = st.miso;
  assign spi_miso_oe       = st.miso_oe;
  assign radio_rx_on       = st.rx_on;
  assign buf_commit        = st.commit;
  assign buf_discard       = st.discard;
  assign sec_start         = st.sec_go;
  assign ack_tx_req        = st.ack_req;
  assign ack_channel       = st.ack_ch;
  assign ack_rate          = st.ack_dr;
  assign ack_frame_pending = st.ack_fp;
  assign repeat_tx_req     = st.rpt_req;
endmodule // rmrc_receive_control

// file: rtl/rmrc_pkg.sv
package rmrc_pkg;

  // ---------------------------------------------------------------
  // Register addresses
  // ---------------------------------------------------------------
  localparam logic [6:0] ADDR_RX_CTRL_ONE  = 7'h15;
  localparam logic [6:0] ADDR_RX_CTRL_TWO  = 7'h16;
  localparam logic [6:0] ADDR_RX_INT_FLAGS = 7'h06;

  // ---------------------------------------------------------------
  // Register fields, modes and buffer counts
  // ---------------------------------------------------------------
  localparam int C1_RECEIVE_ENABLE  = 7;
  localparam int C1_PARSE_DISABLE   = 6;
  localparam int C1_SECURITY_START  = 5;
  localparam int C1_APPEND_LQI      = 4;
  localparam int C1_APPEND_RSSI     = 3;
  localparam int C1_APPEND_CHDR     = 2;
  localparam int C1_APPEND_CFO      = 1;
  localparam logic [7:0] C1_RESET   = 8'h1E;
  localparam int C2_BUFFER_FULL     = 7;
  localparam int C2_DUP_REJECT      = 6;
  localparam int C2_RX_ACK_PENDING  = 5;
  localparam int C2_TX_ACK_PENDING  = 4;
  localparam int C2_AUTO_REPEAT     = 3;
  localparam int C2_AUTO_ACK        = 2;
  localparam int C2_ADAPT_CHANNEL   = 1;
  localparam int C2_ADAPT_RATE      = 0;
  localparam logic [7:0] C2_RESET   = 8'h00;
  localparam int IF_RECEIVE_DONE    = 7;
  localparam int IF_SEC_PASS        = 6;
  localparam int IF_SEC_FAIL        = 5;
  localparam int IF_DUPLICATE       = 3;
  localparam int IF_FILTERED        = 2;
  localparam int IF_OVERFLOW        = 1;
  localparam int IF_STREAM_TIMEOUT  = 0;
  localparam logic [7:0] IF_IMPL_MASK = 8'hEF;
  localparam logic [7:0] IF_RESET   = 8'h00;
  localparam logic [1:0] MODE_PACKET    = 2'h0;
  localparam logic [1:0] MODE_RX_STREAM = 2'h1;
  localparam logic [1:0] MODE_TX_STREAM = 2'h2;
  localparam logic [1:0] BUFS_PACKET    = 2'h1;
  localparam logic [1:0] BUFS_STREAM    = 2'h2;
  localparam logic [1:0] STATUS_FIELDS  = 2'h3;

endpackage : rmrc_pkg

// file: testbench/rmrc_monitor.sv
module rmrc_monitor (
  // Clock and reset
  input wire logic       clk,
  input wire logic       reset_n,
  // Watched ports
  input wire logic       cca_request,
  input wire logic       ack_wait,
  input wire logic       radio_rx_on,
  input wire logic       rx_frame_end,
  input wire logic       rx_byte_ready,
  input wire logic       rx_ack_request,
  input wire logic       rx_repeat,
  input wire logic       rx_std_format,
  input wire logic [3:0] channel_number,
  input wire logic [3:0] ack_channel,
  input wire logic       ack_tx_req,
  input wire logic       repeat_tx_req,
  input wire logic       buf_wr_valid,
  input wire logic       buf_wr_ready,
  input wire logic [7:0] buf_wr_data,
  input wire logic       buf_commit,
  input wire logic       sec_start
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_listen; (cca_request || ack_wait) |=> radio_rx_on; endproperty
  a_listen: assert property (p_listen) else $error("radio not listening");
  property p_ack; ack_tx_req |-> $past(rx_frame_end) && $past(rx_ack_request); endproperty
  a_ack: assert property (p_ack) else $error("ack without request");
  property p_rpt; repeat_tx_req |-> $past(rx_frame_end) && $past(rx_repeat); endproperty
  a_rpt: assert property (p_rpt) else $error("repeat without bit");
  property p_chan; ack_tx_req && $past(rx_std_format) |-> ack_channel == $past(channel_number); endproperty
  a_chan: assert property (p_chan) else $error("ack channel wrong");
  property p_hold; buf_wr_valid && !buf_wr_ready |=> buf_wr_valid && $stable(buf_wr_data); endproperty
  a_hold: assert property (p_hold) else $error("buffer byte dropped");
  property p_commit; buf_commit |-> !buf_wr_valid; endproperty
  a_commit: assert property (p_commit) else $error("commit before drain");
  property p_sec; sec_start |=> !sec_start; endproperty
  a_sec: assert property (p_sec) else $error("security start stuck");
  property p_end; rx_frame_end |=> !rx_byte_ready; endproperty
  a_end: assert property (p_end) else $error("bytes taken after end");
endmodule // rmrc_monitor

// file: testbench/rmrc_host.sv
module rmrc_host (
  // Clock and serial lines
  input wire logic clk,
  output logic     spi_sck,
  output logic     spi_cs_n,
  output logic     spi_mosi,
  input wire logic spi_miso
);
  timeunit 1ns;
  timeprecision 100ps;
  initial {spi_sck, spi_cs_n, spi_mosi} = 3'b010;
  // Four clk per half period gives the 200 ns link clock
  task automatic xfer(input logic [15:0] sh, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk) spi_cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_mosi <= sh[i];
      repeat (4) @(posedge clk);
      spi_sck <= 1'b1;
      rd = {rd[6:0], spi_miso};
      repeat (4) @(posedge clk);
      spi_sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    spi_cs_n <= 1'b1;
    spi_mosi <= ~sh[0];
    repeat (8) @(posedge clk);
  endtask
endmodule // rmrc_host

// file: testbench/rmrc_receive_control_test.sv
bind rmrc_receive_control rmrc_monitor MON (.*);
module rmrc_receive_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic clk = 1'b0;
  logic reset_n, spi_sck, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, crc_check_enable, cca_request, ack_wait;
  logic radio_rx_on, rx_frame_start, rx_byte_valid, rx_byte_ready, rx_frame_end, rx_crc_ok, rx_filter_pass;
  logic rx_is_ack, rx_std_format, rx_frame_pending, rx_repeat, rx_ack_request, frame_format_type, buf_wr_valid;
  logic buf_wr_ready, buf_commit, buf_discard, sec_start, sec_done, sec_pass, ack_tx_req, ack_frame_pending;
  logic repeat_tx_req, stream_timeout;
  logic [1:0] transceiver_mode;
  logic [3:0] channel_number, ack_info_channel, rx_channel, ack_channel;
  logic [2:0] data_rate_code, ack_info_rate, rx_data_rate, ack_rate;
  logic [7:0] rx_byte, rx_seq_num, rx_link_quality, rx_signal_strength, freq_offset_measurement, buf_wr_data, ctrl1;
  logic [15:0] rx_src_addr;
  logic [7:0] gotq[$], expq[$];
  int seed = 84;
  int fail_count = 0, cmp_count = 0, commits = 0, ends = 0, acks = 0, rpts = 0, cycles = 0;
  rmrc_receive_control DUT (.*);
  rmrc_host HOST (.clk, .spi_sck, .spi_cs_n, .spi_mosi, .spi_miso);
  always #12.5 clk = ~clk;
  // Buffer sink stalls at random; security engine answers next cycle
  always @(posedge clk) begin
    buf_wr_ready <= 1'($random(seed));
    sec_done <= sec_start;
    if (buf_wr_valid && buf_wr_ready) gotq.push_back(buf_wr_data);
    commits <= commits + int'(buf_commit);
    ends <= ends + int'(buf_commit | buf_discard);
    acks <= acks + int'(ack_tx_req);
    rpts <= rpts + int'(repeat_tx_req);
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      results();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    cmp_count++;
    if (seen !== want) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic results();
    $display("Compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] want);
    logic [7:0] v;
    HOST.xfer({1'b0, a, 8'h00}, v);
    check("register", v, want);
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] v;
    if (a == rmrc_pkg::ADDR_RX_CTRL_ONE) ctrl1 = d;
    HOST.xfer({1'b1, a, d}, v);
  endtask
  function automatic logic [7:0] chdr();
    return {rx_channel, frame_format_type, rx_data_rate};
  endfunction
  task automatic frame(input bit fresh, input bit filt, input bit abort, input bit want, input logic [7:0] expf);
    logic [7:0] b;
    int n, k, e0, c0, a0, r0;
    n = 1 + int'($unsigned($random(seed)) % 4);
    if (fresh) begin
      {rx_src_addr, rx_seq_num, rx_link_quality, rx_signal_strength, freq_offset_measurement} <=
        48'({$random(seed), $random(seed)});
      {rx_channel, frame_format_type, rx_data_rate, ack_info_channel, ack_info_rate, channel_number, data_rate_code,
        rx_std_format, rx_repeat, rx_ack_request} <= 25'($random(seed));
    end
    rx_filter_pass <= filt;
    expq = {};
    gotq = {};
    e0 = ends;
    c0 = commits;
    a0 = acks;
    r0 = rpts;
    @(posedge clk) rx_frame_start <= 1'b1;
    @(posedge clk) rx_frame_start <= 1'b0;
    repeat (n) begin
      b = 8'($random(seed));
      rx_byte_valid <= 1'b1;
      rx_byte <= b;
      k = 0;
      do @(negedge clk); while (rx_byte_ready !== 1'b1 && ++k < 50);
      @(posedge clk);
      expq.push_back(b);
    end
    rx_byte_valid <= 1'b0;
    if (abort) wr(rmrc_pkg::ADDR_RX_CTRL_ONE, ctrl1 & 8'h7F);
    @(posedge clk) rx_frame_end <= 1'b1;
    @(posedge clk) rx_frame_end <= 1'b0;
    for (k = 0; k < 300 && ends == e0; k++) @(posedge clk);
    if (ctrl1[4]) expq.push_back(rx_link_quality);
    if (ctrl1[3]) expq.push_back(rx_signal_strength);
    if (ctrl1[2]) expq.push_back(chdr());
    if (ctrl1[1]) expq.push_back(freq_offset_measurement);
    check("commit", 8'(commits - c0), 8'(want));
    check("ack", 8'(acks - a0), 8'(want && !ctrl1[6] && rx_ack_request));
    check("repeat", 8'(rpts - r0), 8'(want && !ctrl1[6] && rx_repeat));
    if (want && !ctrl1[6]) check("ack pending", {7'h00, ack_frame_pending}, 8'h00);
    if (want) check("length", 8'(gotq.size()), 8'(expq.size()));
    if (want) foreach (expq[i]) check("buffer byte", gotq[i], expq[i]);
    rchk(rmrc_pkg::ADDR_RX_INT_FLAGS, expf);
  endtask
  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {reset_n, cca_request, ack_wait, rx_frame_start, rx_byte_valid, rx_frame_end, rx_is_ack, rx_frame_pending,
      stream_timeout, sec_pass, sec_done, buf_wr_ready, transceiver_mode, rx_byte, rx_src_addr, rx_seq_num,
      rx_link_quality, rx_signal_strength, freq_offset_measurement, rx_channel, frame_format_type, rx_data_rate,
      ack_info_channel, ack_info_rate, channel_number, data_rate_code, rx_std_format, rx_repeat,
      rx_ack_request} = '0;
    {crc_check_enable, rx_crc_ok, rx_filter_pass} = 3'b111;
    ctrl1 = rmrc_pkg::C1_RESET;
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    for (int k = 0; k < 4; k++) begin
      {cca_request, ack_wait} <= 2'((k + 1) % 4);
      repeat (2) @(posedge clk);
      check("listen", {7'h00, radio_rx_on}, 8'(k < 3));
    end
    rchk(rmrc_pkg::ADDR_RX_CTRL_ONE, rmrc_pkg::C1_RESET);
    rchk(rmrc_pkg::ADDR_RX_CTRL_TWO, rmrc_pkg::C2_RESET);
    rchk(rmrc_pkg::ADDR_RX_INT_FLAGS, rmrc_pkg::IF_RESET);
    rchk(7'h30, 8'h00);
    wr(rmrc_pkg::ADDR_RX_CTRL_ONE, 8'h9F);
    rchk(rmrc_pkg::ADDR_RX_CTRL_ONE, 8'h9E);
    // Adaptive enables stay at 0 for the whole run
    wr(rmrc_pkg::ADDR_RX_CTRL_TWO, 8'h0C);
    frame(1, 1, 0, 1, 8'h80);
    rchk(rmrc_pkg::ADDR_RX_INT_FLAGS, 8'h00);
    rchk(rmrc_pkg::ADDR_RX_CTRL_TWO, 8'h8C);
    frame(0, 1, 0, 0, 8'h02);
    wr(rmrc_pkg::ADDR_RX_CTRL_TWO, 8'h4C);
    frame(0, 1, 0, 0, 8'h08);
    frame(1, 0, 0, 0, 8'h04);
    frame(1, 1, 1, 0, 8'h00);
    wr(rmrc_pkg::ADDR_RX_CTRL_ONE, 8'hC0);
    frame(1, 1, 0, 1, 8'h80);
    for (int p = 1; p >= 0; p--) begin
      sec_pass <= 1'(p);
      wr(rmrc_pkg::ADDR_RX_CTRL_ONE, 8'hE0);
      rchk(rmrc_pkg::ADDR_RX_INT_FLAGS, p ? 8'h40 : 8'h20);
      rchk(rmrc_pkg::ADDR_RX_CTRL_ONE, 8'hC0);
    end
    transceiver_mode <= rmrc_pkg::MODE_TX_STREAM;
    rchk(rmrc_pkg::ADDR_RX_CTRL_ONE, 8'h40);
    transceiver_mode <= rmrc_pkg::MODE_RX_STREAM;
    rchk(rmrc_pkg::ADDR_RX_CTRL_ONE, 8'hC0);
    results();
  end
endmodule // rmrc_receive_control_test
